// ### pdt_pkg.sv
// Constants and types shared by the port default tag and rate control block
package pdt_pkg;

    // Number of switch ports served
    localparam int NUM_PORTS = 3;

    // Register indices as printed; byte address is four times the index
    localparam logic [2:0][7:0] IDX_TAG_HI = {8'h33, 8'h23, 8'h13};
    localparam logic [2:0][7:0] IDX_TAG_LO = {8'h34, 8'h24, 8'h14};
    localparam logic [2:0][7:0] IDX_OPTS = {8'h35, 8'h25, 8'h15};

    // APB address layout
    localparam int ADDR_W = 12;
    localparam int IDX_LSB = 2;

    // Values after reset
    localparam logic [7:0] TAG_HI_RST = 8'h00;
    localparam logic [7:0] TAG_LO_RST = 8'h01;
    localparam logic [7:0] OPTS_RST = 8'h00;

    // Implemented option bits per port; port 2 bit 7 and port 3 bits 6-5 absent
    localparam logic [2:0][7:0] OPTS_MASK = {8'h9f, 8'h7f, 8'hff};

    // Index of the port whose option bit 7 steers the third-port MII role
    localparam int MII_PORT = 2;

    // Field positions in the default tag high byte
    localparam int TAG_PRI_LSB = 5;
    localparam int TAG_CFI_BIT = 4;
    localparam int TAG_VIDH_MSB = 3;

    // Field positions in the ingress options register
    localparam int OPT_MII_MAC_BIT = 7;
    localparam int OPT_SAF1_BIT = 6;
    localparam int OPT_SAF2_BIT = 5;
    localparam int OPT_DROP_TAG_BIT = 4;
    localparam int OPT_MODE_LSB = 2;
    localparam int OPT_GAP_BIT = 1;
    localparam int OPT_PRE_BIT = 0;

    // Per-frame overhead bytes for rate accounting
    localparam int GAP_BYTES = 12;
    localparam int PREAMBLE_BYTES = 8;

    // Null VID value
    localparam logic [11:0] NULL_VID = 12'h000;

    // Ingress limit modes
    typedef enum logic [1:0] {
        LIM_ALL = 2'b00,
        LIM_BC_MC_FLOOD = 2'b01,
        LIM_BC_MC = 2'b10,
        LIM_BC = 2'b11
    } pdt_limit_mode_t;

endpackage : pdt_pkg

// ### pdt_port_ctl.sv
// Port default tag and rate control registers with APB access
`timescale 1ns/100ps
module pdt_port_ctl
    import pdt_pkg::*;
#(
    parameter int LEN_W = 11
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Third-port MII role, high for MAC role
    output logic mii_mac_mode,
    // Ingress descriptors, one slice per port
    input wire logic [NUM_PORTS-1:0] ing_valid,
    input wire logic [NUM_PORTS-1:0] ing_tagged,
    input wire logic [NUM_PORTS*16-1:0] ing_tci,
    input wire logic [NUM_PORTS-1:0] ing_bcast,
    input wire logic [NUM_PORTS-1:0] ing_mcast,
    input wire logic [NUM_PORTS-1:0] ing_flood,
    input wire logic [NUM_PORTS-1:0] ing_sa_match_one,
    input wire logic [NUM_PORTS-1:0] ing_sa_match_two,
    input wire logic [NUM_PORTS*LEN_W-1:0] ing_len,
    // Egress descriptors, one slice per port
    input wire logic [NUM_PORTS-1:0] egr_valid,
    input wire logic [NUM_PORTS*LEN_W-1:0] egr_len,
    // Ingress results
    output logic [NUM_PORTS-1:0] res_valid,
    output logic [NUM_PORTS-1:0] res_drop,
    output logic [NUM_PORTS*16-1:0] res_tci,
    output logic [NUM_PORTS*12-1:0] res_lookup_vid,
    output logic [NUM_PORTS-1:0] res_limited,
    output logic [NUM_PORTS*(LEN_W+1)-1:0] res_bytes,
    // Egress results
    output logic [NUM_PORTS-1:0] egr_res_valid,
    output logic [NUM_PORTS*16-1:0] egr_tci,
    output logic [NUM_PORTS*(LEN_W+1)-1:0] egr_bytes
);

    // Frame lengths below 7 bits cannot hold a minimum frame
    if (LEN_W < 7 || LEN_W > 16)
    begin : g_len_check
        $error("pdt_port_ctl: LEN_W must lie between 7 and 16");
    end

    // Complete register and bus state
    typedef struct packed {
        logic [NUM_PORTS-1:0][7:0] tag_hi;
        logic [NUM_PORTS-1:0][7:0] tag_lo;
        logic [NUM_PORTS-1:0][7:0] opts;
        logic [31:0] rdata;
        logic ack;
        logic err;
    } pdt_ctl_state_t;

    pdt_ctl_state_t state_r;
    pdt_ctl_state_t state_nxt;

    // Address decode results
    logic [7:0] req_idx;
    logic addr_ok;
    logic hit;
    logic [7:0] rd_byte;
    logic access;
    logic done;

    // Address decode: aligned word, index in bits above the byte lane
    always_comb
    begin
        req_idx = paddr[IDX_LSB +: 8];
        addr_ok = (paddr[1:0] == 2'b00)
            && (paddr[ADDR_W-1:IDX_LSB+8] == '0);
        hit = 1'b0;
        rd_byte = 8'h00;
        // Search every port for a matching register
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            if (addr_ok && req_idx == IDX_TAG_HI[p])
            begin
                hit = 1'b1;
                rd_byte = state_r.tag_hi[p];
            end
            if (addr_ok && req_idx == IDX_TAG_LO[p])
            begin
                hit = 1'b1;
                rd_byte = state_r.tag_lo[p];
            end
            if (addr_ok && req_idx == IDX_OPTS[p])
            begin
                hit = 1'b1;
                rd_byte = state_r.opts[p] & OPTS_MASK[p];
            end
        end
    end

    // Access phase, and completion when pready is high
    assign access = psel && penable;
    assign done = access && state_r.ack;

    // Next-state logic: one wait cycle, then answer
    always_comb
    begin
        state_nxt = state_r;
        if (done)
        begin
            // Answer taken; drop the acknowledge
            state_nxt.ack = 1'b0;
            state_nxt.err = 1'b0;
        end
        else if (access)
        begin
            // First access cycle: capture read data and status
            state_nxt.ack = 1'b1;
            state_nxt.err = !hit;
            state_nxt.rdata = (hit && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
        // Writes land on the completing edge only
        if (done && pwrite && hit)
        begin
            for (int p = 0; p < NUM_PORTS; p++)
            begin
                if (req_idx == IDX_TAG_HI[p])
                begin
                    state_nxt.tag_hi[p] = pwdata[7:0];
                end
                if (req_idx == IDX_TAG_LO[p])
                begin
                    state_nxt.tag_lo[p] = pwdata[7:0];
                end
                if (req_idx == IDX_OPTS[p])
                begin
                    // Absent and reserved bits stay zero
                    state_nxt.opts[p] = pwdata[7:0] & OPTS_MASK[p];
                end
            end
        end
    end

    // State register with reset defaults
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int p = 0; p < NUM_PORTS; p++)
            begin
                state_r.tag_hi[p] <= TAG_HI_RST;
                state_r.tag_lo[p] <= TAG_LO_RST;
                state_r.opts[p] <= OPTS_RST;
            end
            state_r.rdata <= 32'h00000000;
            state_r.ack <= 1'b0;
            state_r.err <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Bus answer
    assign pready = state_r.ack;
    assign prdata = state_r.rdata;
    assign pslverr = state_r.err && state_r.ack;

    // Third-port MII role from its own option bit 7
    assign mii_mac_mode = state_r.opts[MII_PORT][OPT_MII_MAC_BIT];

    // One classifier per port
    for (genvar g = 0; g < NUM_PORTS; g++)
    begin : g_port
        pdt_port_filter #(
            .LEN_W(LEN_W)
        ) u_filter (
            .clk(clk),
            .rst(rst),
            .cfg_tag_hi(state_r.tag_hi[g]),
            .cfg_tag_lo(state_r.tag_lo[g]),
            .cfg_opts(state_r.opts[g]),
            .ing_valid(ing_valid[g]),
            .ing_tagged(ing_tagged[g]),
            .ing_tci(ing_tci[g*16 +: 16]),
            .ing_bcast(ing_bcast[g]),
            .ing_mcast(ing_mcast[g]),
            .ing_flood(ing_flood[g]),
            .ing_sa_match_one(ing_sa_match_one[g]),
            .ing_sa_match_two(ing_sa_match_two[g]),
            .ing_len(ing_len[g*LEN_W +: LEN_W]),
            .egr_valid(egr_valid[g]),
            .egr_len(egr_len[g*LEN_W +: LEN_W]),
            .res_valid(res_valid[g]),
            .res_drop(res_drop[g]),
            .res_tci(res_tci[g*16 +: 16]),
            .res_lookup_vid(res_lookup_vid[g*12 +: 12]),
            .res_limited(res_limited[g]),
            .res_bytes(res_bytes[g*(LEN_W+1) +: (LEN_W+1)]),
            .egr_res_valid(egr_res_valid[g]),
            .egr_tci(egr_tci[g*16 +: 16]),
            .egr_bytes(egr_bytes[g*(LEN_W+1) +: (LEN_W+1)])
        );
    end

endmodule : pdt_port_ctl

// ### pdt_port_ctl_chk.sv
// Concurrent checks on the port control block ports
`timescale 1ns/100ps
module pdt_port_ctl_chk
    import pdt_pkg::*;
#(
    parameter int LEN_W = 11
)
(
    // Clock, reset and APB answer
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Ingress descriptors
    input wire logic [NUM_PORTS-1:0] ing_valid,
    input wire logic [NUM_PORTS-1:0] ing_tagged,
    input wire logic [NUM_PORTS*16-1:0] ing_tci,
    input wire logic [NUM_PORTS-1:0] ing_bcast,
    input wire logic [NUM_PORTS-1:0] ing_sa_match_one,
    input wire logic [NUM_PORTS-1:0] ing_sa_match_two,
    input wire logic [NUM_PORTS*LEN_W-1:0] ing_len,
    // Ingress results
    input wire logic [NUM_PORTS-1:0] res_drop,
    input wire logic [NUM_PORTS*16-1:0] res_tci,
    input wire logic [NUM_PORTS*12-1:0] res_lookup_vid,
    input wire logic [NUM_PORTS-1:0] res_limited,
    input wire logic [NUM_PORTS*(LEN_W+1)-1:0] res_bytes
);
    // All checks on the system clock, idle in reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_tag_keep: assert property (
        ing_valid[0] && ing_tagged[0] |=> res_tci[15:0] == $past(ing_tci[15:0]))
        else $error("tagged tci altered");
    chk_vid_given: assert property (
        ing_valid[0] && ing_tagged[0] && ing_tci[11:0] != 12'h000
        |=> res_lookup_vid[11:0] == $past(ing_tci[11:0]))
        else $error("lookup vid not frame vid");
    chk_vid_deflt: assert property (
        ing_valid[0] && !ing_tagged[0] |=> res_lookup_vid[11:0] == res_tci[11:0])
        else $error("lookup vid not default");
    chk_bc_limit: assert property (ing_valid[0] && ing_bcast[0] |=> res_limited[0])
        else $error("broadcast not limited");
    chk_no_drop: assert property (
        ing_valid[0] && !ing_tagged[0] && !ing_sa_match_one[0] && !ing_sa_match_two[0]
        |=> !res_drop[0])
        else $error("clean frame dropped");
    chk_byte_ovh: assert property (
        ing_valid[0] |=> (res_bytes[LEN_W:0] - $past(ing_len[LEN_W-1:0])) inside {0, 8, 12, 20})
        else $error("bad byte overhead");
    chk_ready_one: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("bad ready timing");
    chk_err_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside access phase");

    // Main scenarios reached
    cov_bcast: cover property (ing_valid[0] && ing_bcast[0]);
    cov_err: cover property (pslverr);
    cov_tagged: cover property (ing_valid[0] && ing_tagged[0]);
endmodule : pdt_port_ctl_chk

bind pdt_port_ctl pdt_port_ctl_chk #(.LEN_W(LEN_W)) u_pdt_port_ctl_chk (.*);

// ### pdt_port_filter.sv
// Per-port ingress classification and egress tag/byte accounting
`timescale 1ns/100ps
module pdt_port_filter
    import pdt_pkg::*;
#(
    parameter int LEN_W = 11
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Port configuration
    input wire logic [7:0] cfg_tag_hi,
    input wire logic [7:0] cfg_tag_lo,
    input wire logic [7:0] cfg_opts,
    // Ingress frame descriptor
    input wire logic ing_valid,
    input wire logic ing_tagged,
    input wire logic [15:0] ing_tci,
    input wire logic ing_bcast,
    input wire logic ing_mcast,
    input wire logic ing_flood,
    input wire logic ing_sa_match_one,
    input wire logic ing_sa_match_two,
    input wire logic [LEN_W-1:0] ing_len,
    // Egress frame descriptor
    input wire logic egr_valid,
    input wire logic [LEN_W-1:0] egr_len,
    // Ingress result
    output logic res_valid,
    output logic res_drop,
    output logic [15:0] res_tci,
    output logic [11:0] res_lookup_vid,
    output logic res_limited,
    output logic [LEN_W:0] res_bytes,
    // Egress result
    output logic egr_res_valid,
    output logic [15:0] egr_tci,
    output logic [LEN_W:0] egr_bytes
);

    // Registered result state
    typedef struct packed {
        logic res_valid;
        logic res_drop;
        logic [15:0] res_tci;
        logic [11:0] res_vid;
        logic res_limited;
        logic [LEN_W:0] res_bytes;
        logic egr_valid;
        logic [15:0] egr_tci;
        logic [LEN_W:0] egr_bytes;
    } pdt_filt_state_t;

    pdt_filt_state_t state_r;
    pdt_filt_state_t state_nxt;

    // Port default tag, overhead bytes and limit mode
    logic [15:0] dflt_tci;
    logic [LEN_W:0] overhead;
    pdt_limit_mode_t mode;

    // Default tag, overhead and mode decode
    always_comb
    begin
        dflt_tci = {cfg_tag_hi, cfg_tag_lo};
        overhead = '0;
        if (cfg_opts[OPT_GAP_BIT])
        begin
            overhead = overhead + (LEN_W + 1)'(GAP_BYTES);
        end
        if (cfg_opts[OPT_PRE_BIT])
        begin
            overhead = overhead + (LEN_W + 1)'(PREAMBLE_BYTES);
        end
        mode = pdt_limit_mode_t'(cfg_opts[OPT_MODE_LSB +: 2]);
    end

    // Next-state logic for ingress and egress results
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.res_valid = ing_valid;
        state_nxt.egr_valid = egr_valid;
        if (ing_valid)
        begin
            // Tag assigned to the frame
            state_nxt.res_tci = ing_tagged ? ing_tci : dflt_tci;
            // Lookup VID falls back to the default for untagged or null VID
            if (!ing_tagged || ing_tci[11:0] == NULL_VID)
            begin
                state_nxt.res_vid = dflt_tci[11:0];
            end
            else
            begin
                state_nxt.res_vid = ing_tci[11:0];
            end
            // Drop on tagged ingress or self-address match
            state_nxt.res_drop = (cfg_opts[OPT_DROP_TAG_BIT] && ing_tagged)
                || (cfg_opts[OPT_SAF1_BIT] && ing_sa_match_one)
                || (cfg_opts[OPT_SAF2_BIT] && ing_sa_match_two);
            // Frame class counted against ingress limit
            unique case (mode)
                LIM_ALL: state_nxt.res_limited = 1'b1;
                LIM_BC_MC_FLOOD: state_nxt.res_limited = ing_bcast || ing_mcast || ing_flood;
                LIM_BC_MC: state_nxt.res_limited = ing_bcast || ing_mcast;
                LIM_BC: state_nxt.res_limited = ing_bcast;
            endcase
            state_nxt.res_bytes = {1'b0, ing_len} + overhead;
        end
        if (egr_valid)
        begin
            // Egress insertion uses the port default tag
            state_nxt.egr_tci = dflt_tci;
            state_nxt.egr_bytes = {1'b0, egr_len} + overhead;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign res_valid = state_r.res_valid;
    assign res_drop = state_r.res_drop;
    assign res_tci = state_r.res_tci;
    assign res_lookup_vid = state_r.res_vid;
    assign res_limited = state_r.res_limited;
    assign res_bytes = state_r.res_bytes;
    assign egr_res_valid = state_r.egr_valid;
    assign egr_tci = state_r.egr_tci;
    assign egr_bytes = state_r.egr_bytes;

endmodule : pdt_port_filter

// ### port_default_tag_and_rate_control_bench.sv
// Self-checking bench for the port control block
`timescale 1ns/100ps
module port_default_tag_and_rate_control_bench
    import pdt_pkg::*;
;
    // Clock, reset and APB
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, mii_mac_mode, e;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    // Frame descriptors and results
    logic [2:0] ing_valid = '0, ing_tagged = '0, ing_bcast = '0, ing_mcast = '0;
    logic [2:0] ing_flood = '0, ing_sa_match_one = '0, ing_sa_match_two = '0, egr_valid = '0;
    logic [47:0] ing_tci = '0, res_tci, egr_tci;
    logic [32:0] ing_len = '0, egr_len = '0;
    logic [2:0] res_valid, res_drop, res_limited, egr_res_valid;
    logic [35:0] res_lookup_vid, res_bytes, egr_bytes;
    int failures = 0, compares = 0;

    always #50 clk = ~clk;

    pdt_port_ctl #(.LEN_W(11)) u_pdt_port_ctl (.*);

    // Compare one value
    task check(input string n, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask : check

    // Verdict and end of run
    task complete_run;
        if (failures == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // One APB transfer, entered just after a rising edge
    task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= {24'h5a5a5a, d};
        @(posedge clk);
        penable <= 1;
        // Wait for the answer; only the watchdog ends a hang
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask : apb

    // Register read against expected byte
    task rd(input logic [7:0] i, input logic [7:0] x);
        apb(0, i, 8'h00);
        check("prdata", q, {24'h0, x});
        check("pslverr", e, 0);
    endtask : rd

    // One ingress and one egress descriptor, results sampled next cycle
    task frame(input int p, input logic tg, input logic [15:0] t, input int c, input logic [1:0] s);
        @(posedge clk);
        ing_tagged[p] <= tg;
        ing_tci[p*16+:16] <= t;
        ing_flood[p] <= (c == 1);
        ing_mcast[p] <= (c == 2);
        ing_bcast[p] <= (c == 3);
        ing_sa_match_one[p] <= s[0];
        ing_sa_match_two[p] <= s[1];
        ing_len[p*11+:11] <= 11'd64;
        egr_len[p*11+:11] <= 11'd100;
        ing_valid[p] <= 1;
        egr_valid[p] <= 1;
        @(posedge clk);
        ing_valid[p] <= 0;
        egr_valid[p] <= 0;
        #1;
        check("valid", {res_valid[p], egr_res_valid[p]}, 2'b11);
        // Return on a rising edge so the next request starts there
        @(posedge clk);
    endtask : frame

    // Reset values
    task t_reset;
        for (int p = 0; p < 3; p++)
        begin
            rd(IDX_TAG_HI[p], 8'h00);
            rd(IDX_TAG_LO[p], 8'h01);
            rd(IDX_OPTS[p], 8'h00);
        end
        check("mii", mii_mac_mode, 0);
    endtask : t_reset

    // Option masks, MII role and unmapped access
    task t_opts;
        for (int p = 0; p < 3; p++)
        begin
            apb(1, IDX_OPTS[p], 8'hff);
            rd(IDX_OPTS[p], (p == 1) ? 8'h7f : (p == 2) ? 8'h9f : 8'hff);
        end
        check("mii", mii_mac_mode, 1);
        apb(1, IDX_OPTS[2], 8'h00);
        check("mii", mii_mac_mode, 0);
        apb(1, 8'h16, 8'h3c);
        check("pslverr", e, 1);
        apb(0, 8'hff, 8'h00);
        check("pslverr", e, 1);
        check("prdata", q, 0);
    endtask : t_opts

    // Default tag for untagged, null-VID and tagged frames
    task t_tag;
        for (int p = 0; p < 3; p++)
        begin
            apb(1, IDX_TAG_HI[p], 8'ha3);
            apb(1, IDX_TAG_LO[p], 8'h5c);
            rd(IDX_TAG_HI[p], 8'ha3);
            frame(p, 0, 16'h1234, 0, 2'b00);
            check("tci", res_tci[p*16+:16], 16'ha35c);
            check("egr_tci", egr_tci[p*16+:16], 16'ha35c);
            check("vid", res_lookup_vid[p*12+:12], 12'h35c);
            frame(p, 1, 16'he000, 0, 2'b00);
            check("tci", res_tci[p*16+:16], 16'he000);
            check("vid", res_lookup_vid[p*12+:12], 12'h35c);
            frame(p, 1, 16'h207b, 0, 2'b00);
            check("vid", res_lookup_vid[p*12+:12], 12'h07b);
        end
    endtask : t_tag

    // Tagged drop and self-address filtering
    task t_drop;
        for (int p = 0; p < 3; p++)
        begin
            apb(1, IDX_OPTS[p], 8'h10);
            frame(p, 1, 16'h0005, 0, 2'b00);
            check("drop", res_drop[p], 1);
            frame(p, 0, 16'h0005, 0, 2'b11);
            check("drop", res_drop[p], 0);
            apb(1, IDX_OPTS[p], 8'h40);
            frame(p, 1, 16'h0005, 0, 2'b01);
            check("drop", res_drop[p], p != 2);
            apb(1, IDX_OPTS[p], 8'h20);
            frame(p, 0, 16'h0005, 0, 2'b10);
            check("drop", res_drop[p], p != 2);
        end
    endtask : t_drop

    // Every limit mode against every class, with overhead bytes
    task t_limit;
        int b;
        for (int m = 0; m < 4; m++)
            for (int c = 0; c < 4; c++)
            begin
                apb(1, IDX_OPTS[0], {4'h0, m[1:0], c[1:0]});
                b = (c[1] ? 12 : 0) + (c[0] ? 8 : 0);
                frame(0, 0, 16'h0000, c, 2'b00);
                check("limited", res_limited[0], c >= m);
                check("res_bytes", res_bytes[11:0], 64 + b);
                check("egr_bytes", egr_bytes[11:0], 100 + b);
            end
    endtask : t_limit

    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 0;
        t_reset;
        t_opts;
        t_tag;
        t_drop;
        t_limit;
        // Reset in mid-run must restore every default over written values
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        t_reset;
        complete_run;
    end

    // Watchdog against a hang
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        complete_run;
    end
endmodule : port_default_tag_and_rate_control_bench
